/* core/smc_scratch.v */
// Retained scratch register bank, four bytes
`timescale 1ns/100ps
`default_nettype none
module smc_scratch #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data_q
);
    // One-hot write select, so each cell has a single driver
    wire [DEPTH-1:0] wr_sel = {{(DEPTH-1){1'b0}}, wr_en} << wr_addr;
    wire [WIDTH*DEPTH-1:0] mem_flat;
    genvar i;
    // One retained cell per word; never cleared by sleep
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_cell
            reg [WIDTH-1:0] cell_q;
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    cell_q <= {WIDTH{1'b0}};
                else if (wr_sel[i])
                    cell_q <= wr_data;
            end
            assign mem_flat[i*WIDTH +: WIDTH] = cell_q;
        end
    endgenerate
    // Registered read
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_q <= {WIDTH{1'b0}};
        else
            rd_data_q <= mem_flat[rd_addr*WIDTH +: WIDTH];
    end
endmodule // smc_scratch
`default_nettype wire

/* core/smc_top.v */
// Supply mode, sleep and wake controller top
//
// How it works
// - Normal mode: rail on main supply, both internal domains enabled.
// - Battery mode: rail on battery, core and digital on, metering analog off.
// - Battery mode restarts metering analog when main good and power-down clear.
// - Battery mode after reset selects the 1.024 MHz core clock.
// - Sleep mode: whole 2.5V domain including the core powered down.
// - RAM is flagged invalid after sleep since its domain lost power.
// - Leaving sleep always restarts the core at the reset vector.
// - 3.3V peripherals stay on in sleep, each individually enabled.
// - Sleep holds until a wake-capable event arrives.
// - Four scratch registers keep contents through sleep.
// - Retained configuration registers survive sleep untouched.
// - Temperature change wakes the core unless temperature sensing disabled.
// - Supply change wakes via power vector, masked by its enable bit.
// - Main supply restore always wakes via power vector, unmaskable.
// - Peripheral config bit 6 shows rail is on main supply.
// - Midnight always wakes via clock vector, unmaskable.
// - Programmed alarm wakes via clock vector, maskable.
// - Operating mode follows the rail source; every source change moves mode.
// - Battery to normal restarts metering analog without a core reset.
`timescale 1ns/100ps
`default_nettype none
`include "smc_consts.vh"
module smc_top (
    // Clock and reset
    input wire CLK_SYS,
    input wire ARST_N,
    // Special-function register port from the core
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    output reg [7:0] SFR_RDATA,
    // Supply status from the switchover logic
    input wire RAIL_ON_MAIN,
    input wire MAIN_ABOVE_THRESH,
    // Wake event pulses from the 3.3V peripherals
    input wire TEMP_CHANGE_EV,
    input wire SUPPLY_CHANGE_EV,
    input wire MIDNIGHT_EV,
    input wire ALARM_EV,
    // Domain and core control
    output reg DIGITAL_DOMAIN_EN,
    output reg ANALOG_DOMAIN_EN,
    output reg METERING_ANALOG_EN,
    output reg CORE_RESET_REQ,
    output reg CORE_CLK_SEL,
    output reg RAM_INVALID,
    output reg [1:0] OP_MODE,
    // Interrupt requests to the core
    output wire POWER_EVENT_IRQ,
    output wire CLOCK_EVENT_IRQ,
    // Sleep-time enables for the 3.3V peripherals
    output wire [4:0] PERIPHERAL_CONFIG_SLEEP_EN
);
    localparam ST_NORMAL = 2'h0;
    localparam ST_BATTERY = 2'h1;
    localparam ST_SLEEP = 2'h2;

    // Reset release through two flops
    reg rst_meta_q;
    reg rst_q;
    always @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_q;

    // Address match helper, used by every register outside the scratch window
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Scratch window decode, shared by the write and read paths
    function in_scr;
        input [7:0] addr;
        begin
            in_scr = (addr >= `SMC_ADDR_SCR_A) &&
                (addr <= `SMC_ADDR_SCR_D);
        end
    endfunction

    // Write strobes
    wire wr_irq_en = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_IRQ_EN);
    wire wr_delta = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_DELTA);
    wire wr_peripheral_config = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_PERIPHERAL_CONFIG);
    wire wr_flags = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_FLAGS);
    wire wr_pwrcon = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_PWRCON);
    wire wr_metmode = SFR_WR && hit(SFR_ADDR, `SMC_ADDR_METMODE);
    wire wr_scr = SFR_WR && in_scr(SFR_ADDR);
    wire [7:0] scr_off = SFR_ADDR - `SMC_ADDR_SCR_A;

    // Retained configuration; reset only by power-on, not by sleep
    reg [7:0] irq_en_q;
    reg [7:0] delta_q;
    reg [7:0] peripheral_config_q;
    reg [7:0] metmode_q;
    always @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_en_q <= `SMC_RST_BYTE;
            delta_q <= `SMC_RST_DELTA;
            peripheral_config_q <= `SMC_RST_BYTE;
            metmode_q <= `SMC_RST_BYTE;
        end
        else
        begin
            // Sleep leaves these untouched
            if (wr_irq_en)
                irq_en_q <= SFR_WDATA;
            if (wr_delta)
                delta_q <= SFR_WDATA;
            if (wr_peripheral_config)
                peripheral_config_q <= SFR_WDATA;
            if (wr_metmode)
                metmode_q <= SFR_WDATA;
        end
    end

    // Scratch bank
    wire [7:0] scr_rdata;
    smc_scratch #(
        .WIDTH(8),
        .DEPTH(4),
        .AW(2)
    ) u_scratch (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .wr_en(wr_scr),
        .wr_addr(scr_off[1:0]),
        .wr_data(SFR_WDATA),
        .rd_addr(scr_off[1:0]),
        .rd_data_q(scr_rdata)
    );

    // Mode machine and source tracking
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg rail_q;
    wire rail_up = RAIL_ON_MAIN && !rail_q;
    wire sleep_req = wr_pwrcon && SFR_WDATA[`SMC_BIT_SLEEP_REQ];
    wire temp_on = delta_q[`SMC_BIT_TEMP_EN];
    wire supply_on = irq_en_q[`SMC_BIT_SUPPLY_EN];
    wire alarm_on = irq_en_q[`SMC_BIT_ALARM_EN];

    // Wake qualification
    wire wake_temp = TEMP_CHANGE_EV && temp_on;
    wire wake_supply = SUPPLY_CHANGE_EV && supply_on;
    wire wake_alarm = ALARM_EV && alarm_on;
    wire wake_any = wake_temp || wake_supply || wake_alarm ||
        MIDNIGHT_EV;

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_NORMAL:
                if (!RAIL_ON_MAIN)
                    state_d = ST_BATTERY;
            ST_BATTERY:
                if (RAIL_ON_MAIN)
                    state_d = ST_NORMAL;
                else if (sleep_req)
                    state_d = ST_SLEEP;
            ST_SLEEP:
                if (RAIL_ON_MAIN)
                    state_d = ST_NORMAL;
                else if (wake_any)
                    state_d = ST_BATTERY;
            default:
                state_d = ST_NORMAL;
        endcase
    end

    // Sleep exit requests a core restart at the reset vector
    wire leave_sleep = (state_q == ST_SLEEP) && (state_d != ST_SLEEP);
    always @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_NORMAL;
            rail_q <= 1'b1;
            CORE_RESET_REQ <= 1'b0;
            RAM_INVALID <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rail_q <= RAIL_ON_MAIN;
            CORE_RESET_REQ <= leave_sleep;
            // Cleared by writing the flag register
            if (state_q == ST_SLEEP)
                RAM_INVALID <= 1'b1;
            else if (wr_flags)
                RAM_INVALID <= 1'b0;
        end
    end

    // Latched wake flags; a new event beats a same-cycle clear
    reg [4:0] flags_q;
    wire [4:0] flag_set = {ALARM_EV, MIDNIGHT_EV, rail_up,
        SUPPLY_CHANGE_EV, TEMP_CHANGE_EV};
    always @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            flags_q <= 5'h00;
        else if (wr_flags)
            flags_q <= (flags_q & SFR_WDATA[`SMC_FLG_ALARM:`SMC_FLG_TEMP]) |
                flag_set;
        else
            flags_q <= flags_q | flag_set;
    end

    // Interrupt vectors; restore and midnight bypass the enables
    assign POWER_EVENT_IRQ = flags_q[`SMC_FLG_RESTORE] ||
        (flags_q[`SMC_FLG_SUPPLY] && supply_on) ||
        (flags_q[`SMC_FLG_TEMP] && temp_on);
    assign CLOCK_EVENT_IRQ = flags_q[`SMC_FLG_MIDNIGHT] ||
        (flags_q[`SMC_FLG_ALARM] && alarm_on);
    assign PERIPHERAL_CONFIG_SLEEP_EN = peripheral_config_q[4:0];

    // Domain controls from the next mode
    always @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            DIGITAL_DOMAIN_EN <= 1'b1;
            ANALOG_DOMAIN_EN <= 1'b1;
            METERING_ANALOG_EN <= 1'b1;
            CORE_CLK_SEL <= `SMC_CLK_FULL;
            OP_MODE <= `SMC_MODE_NORMAL;
        end
        else
        begin
            case (state_d)
                ST_NORMAL:
                begin
                    DIGITAL_DOMAIN_EN <= 1'b1;
                    ANALOG_DOMAIN_EN <= 1'b1;
                    METERING_ANALOG_EN <= 1'b1;
                    OP_MODE <= `SMC_MODE_NORMAL;
                end
                ST_BATTERY:
                begin
                    DIGITAL_DOMAIN_EN <= 1'b1;
                    ANALOG_DOMAIN_EN <= 1'b1;
                    METERING_ANALOG_EN <= MAIN_ABOVE_THRESH &&
                        !metmode_q[`SMC_BIT_MET_PDN];
                    OP_MODE <= `SMC_MODE_BATTERY;
                end
                ST_SLEEP:
                begin
                    DIGITAL_DOMAIN_EN <= 1'b0;
                    ANALOG_DOMAIN_EN <= 1'b0;
                    METERING_ANALOG_EN <= 1'b0;
                    OP_MODE <= `SMC_MODE_SLEEP;
                end
                default:
                begin
                    DIGITAL_DOMAIN_EN <= 1'b1;
                    ANALOG_DOMAIN_EN <= 1'b1;
                    METERING_ANALOG_EN <= 1'b1;
                    OP_MODE <= `SMC_MODE_NORMAL;
                end
            endcase
            // Battery clock chosen on entry into battery from normal mode, as after reset, or on sleep exit into battery
            if (state_d == ST_NORMAL)
                CORE_CLK_SEL <= `SMC_CLK_FULL;
            else if ((state_q == ST_NORMAL) || leave_sleep)
                CORE_CLK_SEL <= `SMC_CLK_BATT;
        end
    end

    // Live rail source replaces the stored bit so software always sees it
    reg [7:0] peripheral_config_view;
    always @*
    begin
        peripheral_config_view = peripheral_config_q;
        peripheral_config_view[`SMC_BIT_RAIL_SRC] = RAIL_ON_MAIN;
    end

    // Flag register view: rail, RAM status and latched wake causes
    reg [7:0] flags_view;
    always @*
    begin
        flags_view = `SMC_RST_BYTE;
        flags_view[`SMC_FLG_ALARM:`SMC_FLG_TEMP] = flags_q;
        flags_view[`SMC_FLG_RAM] = RAM_INVALID;
        flags_view[`SMC_FLG_RAIL] = RAIL_ON_MAIN;
    end

    // Read mux; scratch path is one cycle late so data is registered
    reg rd_scr_q;
    always @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            SFR_RDATA <= `SMC_RST_BYTE;
            rd_scr_q <= 1'b0;
        end
        else
        begin
            rd_scr_q <= SFR_RD && in_scr(SFR_ADDR);
            if (SFR_RD)
            begin
                if (hit(SFR_ADDR, `SMC_ADDR_IRQ_EN))
                    SFR_RDATA <= irq_en_q;
                else if (hit(SFR_ADDR, `SMC_ADDR_DELTA))
                    SFR_RDATA <= delta_q;
                else if (hit(SFR_ADDR, `SMC_ADDR_PERIPHERAL_CONFIG))
                    SFR_RDATA <= peripheral_config_view;
                else if (hit(SFR_ADDR, `SMC_ADDR_FLAGS))
                    SFR_RDATA <= flags_view;
                else if (hit(SFR_ADDR, `SMC_ADDR_METMODE))
                    SFR_RDATA <= metmode_q;
                else
                    SFR_RDATA <= `SMC_RST_BYTE;
            end
            else if (rd_scr_q)
                SFR_RDATA <= scr_rdata;
        end
    end
endmodule // smc_top
`default_nettype wire

/* shared/smc_consts.vh */
// Constants for the supply mode, sleep and wake controller
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
// Register offsets
`define SMC_ADDR_IRQ_EN 8'hec
`define SMC_ADDR_DELTA 8'hf3
`define SMC_ADDR_PERIPHERAL_CONFIG 8'hf4
`define SMC_ADDR_FLAGS 8'hf8
`define SMC_ADDR_SCR_A 8'hfb
`define SMC_ADDR_SCR_B 8'hfc
`define SMC_ADDR_SCR_C 8'hfd
`define SMC_ADDR_SCR_D 8'hfe
`define SMC_ADDR_PWRCON 8'hc5
`define SMC_ADDR_METMODE 8'h0b
// Field positions
`define SMC_BIT_RAIL_SRC 6
`define SMC_BIT_SLEEP_REQ 4
`define SMC_BIT_MET_PDN 4
`define SMC_BIT_TEMP_EN 0
`define SMC_BIT_SUPPLY_EN 0
`define SMC_BIT_ALARM_EN 1
`define SMC_FLG_TEMP 0
`define SMC_FLG_SUPPLY 1
`define SMC_FLG_RESTORE 2
`define SMC_FLG_MIDNIGHT 3
`define SMC_FLG_ALARM 4
`define SMC_FLG_RAM 6
`define SMC_FLG_RAIL 7
// Reset values
`define SMC_RST_BYTE 8'h00
`define SMC_RST_DELTA 8'h01
// Clock codes: 0 full rate, 1 the battery rate of 1.024 MHz
`define SMC_CLK_FULL 1'b0
`define SMC_CLK_BATT 1'b1
// Mode encodings
`define SMC_MODE_NORMAL 2'h0
`define SMC_MODE_BATTERY 2'h1
`define SMC_MODE_SLEEP 2'h2
`endif

/* verification/smc_core_model.sv */
// Processor core model on the special-function register port
`timescale 1ns/100ps
`default_nettype none
module smc_core_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic sfr_wr = 1'b0,
    output logic sfr_rd = 1'b0,
    output logic [7:0] sfr_addr = 8'h00,
    output logic [7:0] sfr_wdata = 8'h00,
    input wire logic [7:0] sfr_rdata
);
    // One-cycle strobe; idle address and data inverted so stale values
    // never pass for a live request
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask
    // Software sets sleep settings before sleeping, restores after
    task automatic wr(input logic [7:0] a, d);
        acc(1'b1, a, d);
    endtask
    // Scratch answers one cycle late, so every read waits two
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        repeat (2) @(posedge clk);
        #1 d = sfr_rdata;
    endtask
    // Sleep request, issued only in battery mode
    task automatic sleep;
        acc(1'b1, 8'hc5, 8'h10);
    endtask
endmodule // smc_core_model
`default_nettype wire

/* verification/smc_top_assertions.sv */
// Port assertions for the supply mode controller
`timescale 1ns/100ps
`default_nettype none
module smc_top_assertions (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // Supply and events
    input wire logic RAIL_ON_MAIN,
    input wire logic TEMP_CHANGE_EV,
    input wire logic SUPPLY_CHANGE_EV,
    input wire logic MIDNIGHT_EV,
    input wire logic ALARM_EV,
    // Mode and domains
    input wire logic [1:0] OP_MODE,
    input wire logic DIGITAL_DOMAIN_EN,
    input wire logic ANALOG_DOMAIN_EN,
    input wire logic CORE_RESET_REQ,
    input wire logic RAM_INVALID
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // No wake cause present
    wire quiet;
    assign quiet = !(TEMP_CHANGE_EV | SUPPLY_CHANGE_EV | MIDNIGHT_EV |
        ALARM_EV | RAIL_ON_MAIN);
    // Outputs may trail the mode by one edge, so look at settled modes
    a_sleep_power_off: assert property (OP_MODE == 2'h2 &&
        $past(OP_MODE) == 2'h2 |-> !DIGITAL_DOMAIN_EN && !ANALOG_DOMAIN_EN)
        else $error("domain powered in sleep");
    a_normal_domains_on: assert property (OP_MODE == 2'h0 &&
        $past(OP_MODE) == 2'h0 |-> DIGITAL_DOMAIN_EN && ANALOG_DOMAIN_EN)
        else $error("domain off in normal mode");
    a_battery_digital_on: assert property (OP_MODE == 2'h1 &&
        $past(OP_MODE) == 2'h1 |-> DIGITAL_DOMAIN_EN)
        else $error("digital off in battery mode");
    a_wake_core_reset: assert property ($past(OP_MODE) == 2'h2 &&
        OP_MODE != 2'h2 |-> ##[0:1] CORE_RESET_REQ)
        else $error("no core restart on wake");
    a_reset_one_pulse: assert property (CORE_RESET_REQ |=>
        !CORE_RESET_REQ) else $error("core restart wider than a cycle");
    a_batt_no_reset: assert property ($past(OP_MODE) == 2'h1 &&
        OP_MODE == 2'h0 |-> !CORE_RESET_REQ [*2])
        else $error("core restarted on battery to normal");
    a_ram_flag_sleep: assert property (OP_MODE == 2'h2 [*2]
        |-> RAM_INVALID) else $error("RAM not flagged in sleep");
    a_sleep_holds: assert property (OP_MODE == 2'h2 && quiet &&
        $past(quiet) && $past(quiet, 2) |=> OP_MODE == 2'h2)
        else $error("left sleep with no wake cause");
    a_midnight_wakes: assert property (OP_MODE == 2'h2 &&
        MIDNIGHT_EV |-> ##[1:3] OP_MODE != 2'h2)
        else $error("midnight did not wake");
    a_restore_wakes: assert property (OP_MODE == 2'h2 &&
        $rose(RAIL_ON_MAIN) |-> ##[1:3] OP_MODE == 2'h0)
        else $error("restore did not reach normal mode");
    // Main scenarios
    c_wake: cover property (CORE_RESET_REQ);
    c_restore: cover property (OP_MODE == 2'h2 && $rose(RAIL_ON_MAIN));
    c_midnight: cover property (OP_MODE == 2'h2 && MIDNIGHT_EV);
endmodule // smc_top_assertions
bind smc_top smc_top_assertions i_smc_top_assertions (.CLK_SYS(CLK_SYS),
    .ARST_N(ARST_N), .RAIL_ON_MAIN(RAIL_ON_MAIN),
    .TEMP_CHANGE_EV(TEMP_CHANGE_EV), .SUPPLY_CHANGE_EV(SUPPLY_CHANGE_EV),
    .MIDNIGHT_EV(MIDNIGHT_EV), .ALARM_EV(ALARM_EV), .OP_MODE(OP_MODE),
    .DIGITAL_DOMAIN_EN(DIGITAL_DOMAIN_EN),
    .ANALOG_DOMAIN_EN(ANALOG_DOMAIN_EN),
    .CORE_RESET_REQ(CORE_RESET_REQ), .RAM_INVALID(RAM_INVALID));
`default_nettype wire

/* verification/smc_top_bench.sv */
// Self-checking bench for the supply mode controller
`timescale 1ns/100ps
`default_nettype none
module smc_top_bench;
    logic clk = 0, arst_n = 0, rail = 1, main_ok = 0, wr, rd;
    logic [3:0] ev = 0;
    logic [7:0] addr, wdata, rdata, r, p;
    logic [1:0] mode;
    logic dig, ana, met, crst, csel, rinv, pirq, cirq;
    logic [4:0] psl;
    logic [7:0] sc [$];
    int err_count = 0, n_compared = 0, i, k;
    smc_top i_smc_top (.CLK_SYS(clk), .ARST_N(arst_n), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .RAIL_ON_MAIN(rail), .MAIN_ABOVE_THRESH(main_ok),
        .TEMP_CHANGE_EV(ev[0]), .SUPPLY_CHANGE_EV(ev[1]),
        .MIDNIGHT_EV(ev[2]), .ALARM_EV(ev[3]), .DIGITAL_DOMAIN_EN(dig),
        .ANALOG_DOMAIN_EN(ana), .METERING_ANALOG_EN(met),
        .CORE_RESET_REQ(crst), .CORE_CLK_SEL(csel), .RAM_INVALID(rinv),
        .OP_MODE(mode), .POWER_EVENT_IRQ(pirq), .CLOCK_EVENT_IRQ(cirq),
        .PERIPHERAL_CONFIG_SLEEP_EN(psl));
    smc_core_model i_smc_core_model (.clk(clk), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task complete_run;
        $display("Compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int s);
        @(posedge clk) ev[s] <= 1'b1;
        @(posedge clk) ev[s] <= 1'b0;
    endtask
    // Watchdog well past the expected few hundred cycles
    initial
    begin
        #(40 * 20000);
        err_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(40));
        cyc(10);
        arst_n <= 1'b1;
        cyc(4);
        i_smc_core_model.rd(8'hf3, r); chk("delta", 8'h01, r);
        i_smc_core_model.rd(8'hf4, r); chk("peripheral_config", 8'h40, r);
        i_smc_core_model.rd(8'h50, r); chk("unmapped", 8'h00, r);
        $display("reset values done");
        @(posedge clk) rail <= 1'b0;
        main_ok <= 1'b1;
        cyc(3);
        chk("batt", 8'h1, {6'h0, mode});
        chk("clk_sel", 8'h1, {7'h0, csel});
        i_smc_core_model.wr(8'h0b, 8'h00); cyc(2);
        chk("met_on", 8'h1, {7'h0, met});
        i_smc_core_model.wr(8'h0b, 8'h10); cyc(2);
        chk("met_off", 8'h0, {7'h0, met});
        i_smc_core_model.wr(8'h0b, 8'h00);
        main_ok <= 1'b0;
        $display("battery mode done");
        p = $urandom;
        i_smc_core_model.wr(8'hf4, p);
        for (i = 0; i < 4; i++)
        begin
            sc.push_back(8'($urandom));
            i_smc_core_model.wr(8'(8'hfb + i), sc[i]);
        end
        // Each source with its mask open, then closed
        for (i = 0; i < 8; i++)
        begin
            i_smc_core_model.wr(8'hf3, {7'h0, i < 4});
            i_smc_core_model.wr(8'hec, {6'h0, i < 4, i < 4});
            i_smc_core_model.wr(8'hf8, 8'h00);
            i_smc_core_model.sleep();
            cyc(3);
            chk("sleep", 8'h2, {6'h0, mode});
            chk("ram_inv", 8'h1, {7'h0, rinv});
            pulse(i % 4);
            cyc(4);
            k = (i < 4) ? i : 2;
            chk("wake", (k == i % 4) ? 1 : 2, {6'h0, mode});
            if (k != i % 4)
            begin
                pulse(2);
                cyc(4);
            end
            chk("clk_sel", 8'h1, {7'h0, csel});
            chk("irq", (i < 4 && i % 4 < 2) ? 1 : 2, {6'h0, cirq, pirq});
            i_smc_core_model.rd(8'hf8, r);
            k = (k < 2) ? k : k + 1;
            chk("flag", 8'(1 << k), r & 8'(1 << k));
        end
        for (i = 0; i < 4; i++)
        begin
            i_smc_core_model.rd(8'(8'hfb + i), r);
            chk("scratch", sc[i], r);
        end
        i_smc_core_model.rd(8'hf4, r); chk("peripheral_config", p & 8'hbf, r);
        chk("sleep_en", {3'h0, p[4:0]}, {3'h0, psl});
        $display("wake sources done");
        // Reset again while on battery: mode and clock must settle there
        @(posedge clk) arst_n <= 1'b0;
        cyc(10);
        arst_n <= 1'b1;
        cyc(4);
        chk("rst_mode", 8'h1, {6'h0, mode});
        chk("rst_clk", 8'h1, {7'h0, csel});
        chk("rst_met", 8'h0, {7'h0, met});
        $display("battery reset done");
        i_smc_core_model.wr(8'hf8, 8'h00);
        i_smc_core_model.sleep();
        cyc(3);
        @(posedge clk) rail <= 1'b1;
        cyc(4);
        chk("restore", 8'h0, {6'h0, mode});
        chk("domains", 8'h3, {6'h0, ana, dig});
        chk("psr_irq", 8'h1, {7'h0, pirq});
        i_smc_core_model.rd(8'hf8, r); chk("psr", 8'h04, r & 8'h04);
        i_smc_core_model.rd(8'hf4, r); chk("src", 8'h40, r & 8'h40);
        @(posedge clk) rail <= 1'b0;
        cyc(3);
        chk("met_batt", 8'h0, {7'h0, met});
        @(posedge clk) rail <= 1'b1;
        cyc(3);
        chk("met_back", 8'h1, {7'h0, met});
        chk("clk_full", 8'h0, {7'h0, csel});
        $display("restore done");
        complete_run();
    end
endmodule // smc_top_bench
`default_nettype wire
